// ==== test/cpu_stack_model.sv ====
// cpu-side model: status stack and program-counter push handshake
`timescale 1ns/1ps
`default_nettype none
module cpu_stack_model (
  input  wire logic       clk,         // cpu clock
  input  wire logic       rst_b,       // async reset, active low
  input  wire logic       stack_push,  // status push request
  input  wire logic [7:0] stack_wdata, // status being pushed
  input  wire logic       pc_push,     // pc push request
  input  wire logic       pop,         // pop, return_from_service or return_from_soft_trap
  input  wire logic [3:0] lat,         // extra cycles before the pc push completes
  output logic            pc_pushed,   // pc push done pulse
  output logic      [7:0] stack_rdata  // top of stack
);
  logic [7:0] mem [16];
  logic [3:0] sp;
  logic [4:0] wait_cnt;
  // an empty stack shows the inverse of the last push, so a stale value never passes
  assign stack_rdata = (sp == 4'h0) ? ~stack_wdata : mem[sp - 4'h1];
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sp <= 4'h0;
      wait_cnt <= 5'h00;
      pc_pushed <= 1'b0;
    end else begin
      pc_pushed <= (wait_cnt == 5'h01);
      if (pc_push) begin
        wait_cnt <= {1'b0, lat} + 5'h01;
      end else if (wait_cnt != 5'h00) begin
        wait_cnt <= wait_cnt - 5'h01;
      end
      if (stack_push) begin
        mem[sp] <= stack_wdata;
        sp <= sp + 4'h1;
      end else if (pop && sp != 4'h0) begin
        sp <= sp - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== test/vectored_interrupt_control_tb_top.sv ====
// self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "vic_defs.svh"
module vectored_interrupt_control_tb_top;
  logic        clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_wr16 = 1'b0, reg_rd = 1'b0;
  logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, reg_rdata, vec_addr, last_vec;
  logic [23:0] src_req = 24'h0;
  logic [3:0]  ext_pin = 4'h0, lat = 4'h0;
  logic        nmi_req = 1'b0, wdt_mode1 = 1'b0, instr_end = 1'b0, div_busy = 1'b0;
  logic [6:0]  cmds = 7'h00; // ei di trap push pop return_from_service return_from_soft_trap
  logic [7:0]  stack_rdata, stack_wdata, status_word, last_push;
  logic        pc_pushed, stack_push, pc_push, vec_load;
  int          bad_count = 0, cmp_count = 0, push_cnt = 0, vec_cnt = 0, cyc = 0;
  integer      seed = 25;
  localparam int EI = 0, DI = 1, TRAP = 2, PUSH = 3, POP = 4, RETURN_FROM_SERVICE = 5, RETURN_FROM_SOFT_TRAP = 6;
  logic [15:0] adr [9] = '{`VIC_ADDR_RISE, `VIC_ADDR_FALL, `VIC_ADDR_BLOCK_A, `VIC_ADDR_BLOCK_B,
    `VIC_ADDR_BLOCK_C, `VIC_ADDR_LEVEL_A, `VIC_ADDR_LEVEL_B, `VIC_ADDR_LEVEL_C, `VIC_ADDR_STATUS};
  logic [7:0]  rv [9] = '{8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h02};

  vectored_interrupt_control DUT (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_wr16(reg_wr16), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .src_req(src_req), .ext_pin(ext_pin), .nmi_req(nmi_req),
    .wdt_mode1(wdt_mode1), .instr_end(instr_end), .div_busy(div_busy), .cmd_ei(cmds[EI]),
    .cmd_di(cmds[DI]), .cmd_trap(cmds[TRAP]), .cmd_push(cmds[PUSH]), .cmd_pop(cmds[POP]),
    .cmd_return_from_service(cmds[RETURN_FROM_SERVICE]), .cmd_return_from_soft_trap(cmds[RETURN_FROM_SOFT_TRAP]), .stack_rdata(stack_rdata),
    .pc_pushed(pc_pushed), .stack_push(stack_push), .stack_wdata(stack_wdata),
    .pc_push(pc_push), .vec_load(vec_load), .vec_addr(vec_addr), .status_word(status_word));
  cpu_stack_model u_cpu (.clk(clk), .rst_b(rst_b), .stack_push(stack_push),
    .stack_wdata(stack_wdata), .pc_push(pc_push), .pop(cmds[POP] | cmds[RETURN_FROM_SERVICE] | cmds[RETURN_FROM_SOFT_TRAP]),
    .lat(lat), .pc_pushed(pc_pushed), .stack_rdata(stack_rdata));

  always #20 clk = ~clk;
  // the run needs under a thousand cycles; the ceiling only cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (stack_push) begin
      push_cnt <= push_cnt + 1;
      last_push <= stack_wdata;
    end
    if (vec_load) begin
      vec_cnt <= vec_cnt + 1;
      last_vec <= vec_addr;
    end
    if (cyc == 20000) begin
      bad_count++;
      stop_test();
    end
  end

  function automatic logic [15:0] exp_vec(input int ord, input logic nmi);
    return nmi ? `VIC_NMI_VECTOR : `VIC_VEC_BASE + 16'(2 * ord);
  endfunction
  function automatic logic [7:0] exp_st(input logic [7:0] s, input logic lvl, nmi);
    return nmi ? (s & 8'h7d) : {1'b0, s[6:2], lvl, s[0]};
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic op(input int k);
    cmds[k] = 1'b1;
    tick();
    cmds = 7'h00;
    tick();
  endtask
  task automatic req(input logic [23:0] m, input logic n = 1'b0);
    src_req = m;
    nmi_req = n;
    tick();
    src_req = 24'h0;
    nmi_req = 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, d, input logic w16 = 1'b0);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = !w16;
    reg_wr16 = w16;
    tick();
    reg_wr = 1'b0;
    reg_wr16 = 1'b0;
    tick();
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    tick();
    reg_rd = 1'b0;
    tick();
    d = reg_rdata[7:0];
  endtask
  // one instruction boundary, then wait a bounded time for a vector load
  task automatic bound(output logic took);
    int v;
    v = vec_cnt;
    lat = 4'($random(seed));
    instr_end = 1'b1;
    tick();
    instr_end = 1'b0;
    // a taken request must vector inside the high-group latency ceiling
    for (int i = 0; i < `VIC_LAT_MAX_HI && vec_cnt == v; i++) tick();
    took = (vec_cnt != v);
  endtask
  task automatic accept(input int ord, input logic lvl, nmi, take);
    logic t;
    logic [7:0] s0;
    s0 = status_word;
    bound(t);
    chk("taken", t, take);
    if (take) begin
      chk("vector", last_vec, exp_vec(ord, nmi));
      chk("pushed status", last_push, s0);
      chk("status", status_word, exp_st(s0, lvl, nmi));
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    logic [7:0] d;
    logic [15:0] r;
    logic t;
    int v;
    repeat (16) @(posedge clk);
    #1 rst_b = 1'b1;
    tick();
    chk("status port", status_word, 8'h02);
    foreach (adr[i]) begin
      rd(adr[i], d);
      chk("reset value", d, rv[i]);
    end
    foreach (adr[i]) begin
      d = 8'($random(seed));
      if (i < 2) d[7:4] = 4'h0;
      wr(adr[i], {8'h00, d});
      rd(adr[i], r[7:0]);
      chk("byte rw", r[7:0], d);
    end
    for (int k = 0; k < 2; k++) begin
      r = 16'($random(seed));
      wr(k ? `VIC_ADDR_LEVEL_A : `VIC_ADDR_BLOCK_A, r, 1'b1);
      rd(k ? `VIC_ADDR_LEVEL_A : `VIC_ADDR_BLOCK_A, d);
      chk("low of pair", d, r[7:0]);
      chk("pair word", reg_rdata, r);
      rd(k ? `VIC_ADDR_LEVEL_B : `VIC_ADDR_BLOCK_B, d);
      chk("high of pair", d, r[15:8]);
    end
    wdt_mode1 = 1'b1;
    wr(`VIC_ADDR_REQ_A, 16'h0000);
    wr(`VIC_ADDR_BLOCK_A, 16'h00ff);
    rd(`VIC_ADDR_BLOCK_A, d);
    chk("watchdog blocked read", d, 8'hfe);
    wdt_mode1 = 1'b0;
    wr(`VIC_ADDR_BLOCK_B, 16'h00ff);
    wr(`VIC_ADDR_LEVEL_B, 16'h00ff);
    $display("test registers done");
    wr(`VIC_ADDR_BLOCK_A, 16'h00e1);
    wr(`VIC_ADDR_LEVEL_A, 16'h00ef);
    wr(`VIC_ADDR_REQ_A, 16'h0000);
    wr(`VIC_ADDR_STATUS, 16'h0002);
    op(EI);
    req(24'h00000c);
    accept(2, 1'b1, 1'b0, 1'b1);
    accept(3, 1'b1, 1'b0, 1'b0);
    op(RETURN_FROM_SERVICE);
    chk("status restored", status_word, 8'h82);
    req(24'h000010);
    accept(4, 1'b0, 1'b0, 1'b1);
    op(EI);
    accept(3, 1'b1, 1'b0, 1'b0);
    op(RETURN_FROM_SERVICE);
    accept(3, 1'b1, 1'b0, 1'b1);
    op(RETURN_FROM_SERVICE);
    wr(`VIC_ADDR_BLOCK_A, 16'h00e3);
    req(24'h000002);
    accept(1, 1'b1, 1'b0, 1'b0);
    rd(`VIC_ADDR_REQ_A, d);
    chk("request bits", d, 8'h02);
    wr(`VIC_ADDR_BLOCK_A, 16'h00e1);
    div_busy = 1'b1;
    accept(1, 1'b1, 1'b0, 1'b0);
    div_busy = 1'b0;
    accept(1, 1'b1, 1'b0, 1'b1);
    op(RETURN_FROM_SERVICE);
    $display("test maskable done");
    op(DI);
    req(24'h000000, 1'b1);
    accept(0, 1'b0, 1'b1, 1'b1);
    req(24'h000000, 1'b1);
    tick();
    req(24'h000000, 1'b1);
    accept(0, 1'b0, 1'b1, 1'b0);
    op(RETURN_FROM_SERVICE);
    v = vec_cnt;
    repeat (3) bound(t);
    chk("pending nmi accepts", 16'(vec_cnt - v), 16'h0001);
    chk("nmi vector", last_vec, `VIC_NMI_VECTOR);
    op(RETURN_FROM_SERVICE);
    $display("test non-maskable done");
    op(EI);
    v = push_cnt;
    op(TRAP);
    tick(4);
    chk("trap push", 16'(push_cnt - v), 16'h0001);
    chk("trap enable", status_word[7], 1'b0);
    op(RETURN_FROM_SOFT_TRAP);
    chk("trap return", status_word, 8'h82);
    op(PUSH);
    op(DI);
    op(POP);
    tick();
    chk("pop status", status_word, 8'h82);
    $display("test stack done");
    wr(`VIC_ADDR_BLOCK_A, 16'h00ff);
    for (int c = 0; c < 4; c++) begin
      wr(`VIC_ADDR_RISE, 16'(c[1]));
      wr(`VIC_ADDR_FALL, 16'(c[0]));
      wr(`VIC_ADDR_REQ_A, 16'h0000);
      ext_pin[0] = 1'b1;
      tick(4);
      rd(`VIC_ADDR_REQ_A, d);
      chk("rising edge", d[1], c[1]);
      wr(`VIC_ADDR_REQ_A, 16'h0000);
      ext_pin[0] = 1'b0;
      tick(4);
      rd(`VIC_ADDR_REQ_A, d);
      chk("falling edge", d[1], c[0]);
    end
    $display("test edges done");
    stop_test();
  end
endmodule
`default_nettype wire

// ==== verilog/vectored_interrupt_control.sv ====
// vectored interrupt control: flag banks, edge select, status word, arbitration
// Overview of operation
// - blocked bit set gates its source off
// - level bit zero means high group
// - rise/fall pair selects external pin edge
// - low pairs readable and writable as 16 bits; the request pair takes byte writes only
// - status word resets 02h, byte/bit/enable ops
// - accept or trap pushes status, clears enable
// - maskable accept copies level bit to priority bit
// - push/pop/returns save and restore status word
// - non-maskable accepted regardless, outranks all
// - non-maskable accept pushes, clears both, vectors
// - nested non-maskable waits return plus one instruction
// - many non-maskable requests collapse into one
// - eligible when requested, unblocked, enable set
// - high handler running blocks low group
// - latency 7-32 high, 8-33 low clocks
// - divide instruction may stretch latency
// - high group first, then default order
// - pending request stays latched until accepted
// - maskable accept pushes, clears enable, vectors
// - watchdog blocked bit reads undefined in mode 1
// - request set by source, cleared on accept
// - default order zero highest, 23 lowest
// - watchdog non-maskable vector is 0004h
`timescale 1ns/1ps
`default_nettype none
`include "vic_defs.svh"
module vectored_interrupt_control
  import vic_pkg::*;
(
  input  wire logic        clk,          // cpu clock
  input  wire logic        rst_b,        // async reset, active low
  input  wire logic [15:0] reg_addr,     // register address
  input  wire logic [15:0] reg_wdata,    // write data, high byte for 16-bit
  input  wire logic        reg_wr,       // byte write strobe
  input  wire logic        reg_wr16,     // 16-bit write strobe
  input  wire logic        reg_rd,       // read strobe
  output logic      [15:0] reg_rdata,    // registered read data
  input  wire logic [23:0] src_req,      // internal request pulses, bit = default order
  input  wire logic [3:0]  ext_pin,      // external_interrupt_pins
  input  wire logic        nmi_req,      // watchdog_overflow_request, non-maskable
  input  wire logic        wdt_mode1,    // watchdog in mode 1
  input  wire logic        instr_end,    // instruction boundary
  input  wire logic        div_busy,     // divide in progress
  input  wire logic        cmd_ei,       // unmask_all_instr
  input  wire logic        cmd_di,       // mask_all_instr
  input  wire logic        cmd_trap,     // soft_trap_instr
  input  wire logic        cmd_push,     // push status word
  input  wire logic        cmd_pop,      // pop status word, data on stack_rdata
  input  wire logic        cmd_return_from_service,     // return_from_service, data on stack_rdata
  input  wire logic        cmd_return_from_soft_trap,     // return_from_soft_trap
  input  wire logic [7:0]  stack_rdata,  // status word popped from stack
  input  wire logic        pc_pushed,    // cpu finished pushing pc
  output logic             stack_push,   // push status word request
  output logic      [7:0]  stack_wdata,  // status word to push
  output logic             pc_push,      // push pc request
  output logic             vec_load,     // load pc from vector table
  output logic      [15:0] vec_addr,     // vector table address
  output logic      [7:0]  status_word   // current status word
);
  logic [7:0]  rise_sel;
  logic [7:0]  fall_sel;
  logic [23:0] blocked;
  logic [23:0] level;
  logic [23:0] request;
  logic [3:0]  pin_prev;
  logic        nmi_pend;
  logic        nmi_active;
  logic        nmi_gap;
  logic [4:0]  win_idx;
  logic        win_nmi;
  acc_state_t  state;
  acc_state_t  next_state;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
    hit = (a == o);
  endfunction

  // 16-bit access addresses the low byte; the odd byte follows it
  wire wr8  = reg_wr & ~reg_wr16;
  wire [7:0] wlo = reg_wdata[7:0];
  wire [7:0] whi = reg_wdata[15:8];
  wire wr_rise = wr8 & hit(reg_addr, `VIC_ADDR_RISE);
  wire wr_fall = wr8 & hit(reg_addr, `VIC_ADDR_FALL);
  wire wr_ba   = (reg_wr | reg_wr16) & hit(reg_addr, `VIC_ADDR_BLOCK_A);
  wire wr_bb   = (wr8 & hit(reg_addr, `VIC_ADDR_BLOCK_B))
               | (reg_wr16 & hit(reg_addr, `VIC_ADDR_BLOCK_A));
  wire wr_bc   = wr8 & hit(reg_addr, `VIC_ADDR_BLOCK_C);
  wire wr_la   = (reg_wr | reg_wr16) & hit(reg_addr, `VIC_ADDR_LEVEL_A);
  wire wr_lb   = (wr8 & hit(reg_addr, `VIC_ADDR_LEVEL_B))
               | (reg_wr16 & hit(reg_addr, `VIC_ADDR_LEVEL_A));
  wire wr_lc   = wr8 & hit(reg_addr, `VIC_ADDR_LEVEL_C);
  wire wr_st   = wr8 & hit(reg_addr, `VIC_ADDR_STATUS);
  wire [7:0] bb_data = reg_wr16 ? whi : wlo;
  wire [7:0] lb_data = reg_wr16 ? whi : wlo;

  // edge detection on the four external pins
  wire [3:0] rise_edge = ext_pin & ~pin_prev & rise_sel[3:0];
  wire [3:0] fall_edge = ~ext_pin & pin_prev & fall_sel[3:0];
  wire [23:0] raise_vec = src_req | {19'h00000, rise_edge | fall_edge, 1'b0};

  // eligibility: requested and unblocked, then group gating by priority bit
  wire        ie  = status_word[`VIC_BIT_ENABLE];
  wire        service_priority_bit = status_word[`VIC_BIT_PRIO];
  wire [23:0] elig    = request & ~blocked;
  wire [23:0] elig_hi = elig & ~level;
  wire [23:0] elig_lo = service_priority_bit ? (elig & level) : 24'h000000;
  wire [23:0] cand    = (|elig_hi) ? elig_hi : elig_lo;

  // lowest index wins within the chosen group
  logic [4:0] pick;
  always_comb begin
    pick = 5'h00;
    for (int i = `VIC_NSRC - 1; i >= 0; i--) begin
      if (cand[i]) begin
        pick = 5'(i);
      end
    end
  end

  // only at an instruction boundary, never mid-divide; late divide adds latency
  wire boundary = instr_end & ~div_busy;
  wire take_nmi = boundary & nmi_pend & ~nmi_active & ~nmi_gap & (state == ST_IDLE);
  wire take_mi  = boundary & ie & (|cand) & ~take_nmi & (state == ST_IDLE);
  wire trap_now = cmd_trap & (state == ST_IDLE);

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:   next_state = (take_nmi | take_mi) ? ST_PUSH_S : ST_IDLE;
      ST_PUSH_S: next_state = ST_PUSH_P;
      ST_PUSH_P: next_state = pc_pushed ? ST_VECTOR : ST_PUSH_P;
      ST_VECTOR: next_state = ST_IDLE;
      default:   next_state = ST_IDLE;
    endcase
  end

  // status word next value; accept and pops outrank byte writes and ei/di
  logic [7:0] next_status;
  always_comb begin
    next_status = status_word;
    if (wr_st) next_status = wlo;
    if (cmd_ei) next_status[`VIC_BIT_ENABLE] = 1'b1;
    if (cmd_di) next_status[`VIC_BIT_ENABLE] = 1'b0;
    if (cmd_pop | cmd_return_from_service | cmd_return_from_soft_trap) next_status = stack_rdata;
    if (trap_now) next_status[`VIC_BIT_ENABLE] = 1'b0;
    if (take_mi) begin
      next_status[`VIC_BIT_ENABLE] = 1'b0;
      next_status[`VIC_BIT_PRIO]   = level[pick];
    end
    if (take_nmi) begin
      next_status[`VIC_BIT_ENABLE] = 1'b0;
      next_status[`VIC_BIT_PRIO]   = 1'b0;
    end
  end

  // request bits: source set wins over a software clear in the same cycle
  wire [23:0] clr_acc = take_mi ? (24'h000001 << pick) : 24'h000000;
  logic [23:0] next_request;
  always_comb begin
    next_request = request;
    if (wr8 & hit(reg_addr, `VIC_ADDR_REQ_A)) next_request[7:0] = wlo;
    if (wr8 & hit(reg_addr, `VIC_ADDR_REQ_B)) next_request[15:8] = wlo;
    if (wr8 & hit(reg_addr, `VIC_ADDR_REQ_C)) next_request[23:16] = wlo;
    next_request = (next_request & ~clr_acc) | raise_vec;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rise_sel <= `VIC_RST_EDGE;
      fall_sel <= `VIC_RST_EDGE;
      blocked  <= {3{`VIC_RST_BLOCK}};
      level    <= {3{`VIC_RST_LEVEL}};
      request  <= 24'h000000;
      status_word <= `VIC_RST_STATUS;
      pin_prev <= 4'h0;
    end else begin
      if (wr_rise) rise_sel <= {4'h0, wlo[3:0]};
      if (wr_fall) fall_sel <= {4'h0, wlo[3:0]};
      if (wr_ba) blocked[7:0]   <= wlo;
      if (wr_bb) blocked[15:8]  <= bb_data;
      if (wr_bc) blocked[23:16] <= wlo;
      if (wr_la) level[7:0]     <= wlo;
      if (wr_lb) level[15:8]    <= lb_data;
      if (wr_lc) level[23:16]   <= wlo;
      request     <= next_request;
      status_word <= next_status;
      pin_prev    <= ext_pin;
    end
  end

  // non-maskable: one pending flag absorbs repeats; gap holds off one instruction
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      nmi_pend   <= 1'b0;
      nmi_active <= 1'b0;
      nmi_gap    <= 1'b0;
    end else begin
      if (nmi_req) nmi_pend <= 1'b1;
      else if (take_nmi) nmi_pend <= 1'b0;
      if (take_nmi) nmi_active <= 1'b1;
      else if (cmd_return_from_service & nmi_active) nmi_active <= 1'b0;
      if (cmd_return_from_service & nmi_active) nmi_gap <= 1'b1;
      else if (instr_end) nmi_gap <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state   <= ST_IDLE;
      win_idx <= 5'h00;
      win_nmi <= 1'b0;
    end else begin
      state <= next_state;
      if (take_nmi | take_mi) begin
        win_idx <= pick;
        win_nmi <= take_nmi;
      end
    end
  end

  // cpu handshake outputs, all registered
  wire [15:0] mi_vec = `VIC_VEC_BASE + {10'h000, win_idx, 1'b0};
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stack_push  <= 1'b0;
      stack_wdata <= 8'h00;
      pc_push     <= 1'b0;
      vec_load    <= 1'b0;
      vec_addr    <= 16'h0000;
    end else begin
      stack_push <= take_nmi | take_mi | trap_now | cmd_push;
      if (take_nmi | take_mi | trap_now | cmd_push) stack_wdata <= status_word;
      pc_push  <= (next_state == ST_PUSH_P) & (state == ST_PUSH_S);
      vec_load <= (state == ST_VECTOR);
      if (state == ST_VECTOR) vec_addr <= win_nmi ? `VIC_NMI_VECTOR : mi_vec;
    end
  end

  // read mux; watchdog blocked bit reads as don't-care zero in mode 1
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    case (reg_addr)
      `VIC_ADDR_RISE:    rd_mux = {8'h00, rise_sel};
      `VIC_ADDR_FALL:    rd_mux = {8'h00, fall_sel};
      `VIC_ADDR_BLOCK_A: rd_mux = {blocked[15:8], blocked[7:1], blocked[0] & ~wdt_mode1};
      `VIC_ADDR_BLOCK_B: rd_mux = {8'h00, blocked[15:8]};
      `VIC_ADDR_BLOCK_C: rd_mux = {8'h00, blocked[23:16]};
      `VIC_ADDR_LEVEL_A: rd_mux = level[15:0];
      `VIC_ADDR_LEVEL_B: rd_mux = {8'h00, level[15:8]};
      `VIC_ADDR_LEVEL_C: rd_mux = {8'h00, level[23:16]};
      `VIC_ADDR_REQ_A:   rd_mux = request[15:0];
      `VIC_ADDR_REQ_B:   rd_mux = {8'h00, request[15:8]};
      `VIC_ADDR_REQ_C:   rd_mux = {8'h00, request[23:16]};
      `VIC_ADDR_STATUS:  rd_mux = {8'h00, status_word};
      default:           rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) reg_rdata <= 16'h0000;
    else if (reg_rd) reg_rdata <= rd_mux;
  end

  // assertions
  property p_nmi_first;
    @(posedge clk) disable iff (!rst_b) take_nmi |-> !take_mi;
  endproperty
  a_nmi_first: assert property (p_nmi_first) else $error("maskable taken over nmi");
  property p_block;
    @(posedge clk) disable iff (!rst_b) take_mi |-> !blocked[pick] && request[pick];
  endproperty
  a_block: assert property (p_block) else $error("blocked source accepted");
  property p_low_gate;
    @(posedge clk) disable iff (!rst_b) (take_mi && !service_priority_bit) |-> !level[pick];
  endproperty
  a_low_gate: assert property (p_low_gate) else $error("low group under high");
  property p_ie_clear;
    @(posedge clk) disable iff (!rst_b) take_mi |=> !status_word[`VIC_BIT_ENABLE];
  endproperty
  a_ie_clear: assert property (p_ie_clear) else $error("enable not cleared");
  property p_isp_copy;
    @(posedge clk) disable iff (!rst_b)
      take_mi |=> status_word[`VIC_BIT_PRIO] == $past(level[pick]);
  endproperty
  a_isp_copy: assert property (p_isp_copy) else $error("priority bit not copied");
  property p_nmi_clear;
    @(posedge clk) disable iff (!rst_b)
      take_nmi |=> !status_word[`VIC_BIT_ENABLE] && !status_word[`VIC_BIT_PRIO];
  endproperty
  a_nmi_clear: assert property (p_nmi_clear) else $error("nmi flags not cleared");
  property p_push_status;
    @(posedge clk) disable iff (!rst_b)
      (take_mi || take_nmi) |=> stack_push && stack_wdata == $past(status_word);
  endproperty
  a_push_status: assert property (p_push_status) else $error("status not pushed");
  property p_req_clear;
    @(posedge clk) disable iff (!rst_b)
      (take_mi && !raise_vec[pick]) |=> !request[$past(pick)];
  endproperty
  a_req_clear: assert property (p_req_clear) else $error("request not cleared");
  property p_nmi_vec;
    @(posedge clk) disable iff (!rst_b)
      (vec_load && win_nmi) |-> vec_addr == `VIC_NMI_VECTOR;
  endproperty
  a_nmi_vec: assert property (p_nmi_vec) else $error("nmi vector wrong");
  property p_boundary;
    @(posedge clk) disable iff (!rst_b) (take_mi || take_nmi) |-> instr_end && !div_busy;
  endproperty
  a_boundary: assert property (p_boundary) else $error("accept off boundary");
  // an accept must drive the whole push sequence without stalling
  property p_accept_seq;
    @(posedge clk) disable iff (!rst_b) (take_mi || take_nmi) |=> stack_push ##1 pc_push;
  endproperty
  a_accept_seq: assert property (p_accept_seq) else $error("push sequence broken");
  property p_trap_push;
    @(posedge clk) disable iff (!rst_b)
      trap_now |=> stack_push && !status_word[`VIC_BIT_ENABLE];
  endproperty
  a_trap_push: assert property (p_trap_push) else $error("trap did not push");
  property p_ei_set;
    @(posedge clk) disable iff (!rst_b)
      (cmd_ei && !cmd_di && !trap_now && !take_mi && !take_nmi && !cmd_pop && !cmd_return_from_service
        && !cmd_return_from_soft_trap) |=> status_word[`VIC_BIT_ENABLE];
  endproperty
  a_ei_set: assert property (p_ei_set) else $error("enable not set");
  // a restore is the only path that loads a whole stacked word
  property p_restore;
    @(posedge clk) disable iff (!rst_b)
      ((cmd_pop || cmd_return_from_service || cmd_return_from_soft_trap) && !trap_now && !take_mi && !take_nmi)
        |=> status_word == $past(stack_rdata);
  endproperty
  a_restore: assert property (p_restore) else $error("status not restored");
  property p_nmi_hold;
    @(posedge clk) disable iff (!rst_b) (cmd_return_from_service && nmi_active) |=> !take_nmi;
  endproperty
  a_nmi_hold: assert property (p_nmi_hold) else $error("nmi taken too early");
  property p_nmi_once;
    @(posedge clk) disable iff (!rst_b) (take_nmi && !nmi_req) |=> !nmi_pend;
  endproperty
  a_nmi_once: assert property (p_nmi_once) else $error("nmi left pending");
  // a source pulse lands even when software or an accept clears that bit
  property p_req_set;
    @(posedge clk) disable iff (!rst_b)
      (|raise_vec) |=> (request & $past(raise_vec)) == $past(raise_vec);
  endproperty
  a_req_set: assert property (p_req_set) else $error("request pulse lost");
  property p_high_first;
    @(posedge clk) disable iff (!rst_b)
      (take_mi && (|(request & ~blocked & ~level))) |-> !level[pick];
  endproperty
  a_high_first: assert property (p_high_first) else $error("low group beat high");
  // no eligible source of the winner's group may sit at a lower index
  property p_default_order;
    @(posedge clk) disable iff (!rst_b)
      take_mi |-> (request & ~blocked & ~(level ^ {24{level[pick]}})
        & ((24'h000001 << pick) - 24'h000001)) == 24'h000000;
  endproperty
  a_default_order: assert property (p_default_order) else $error("order broken");
  // each enabled pin edge must raise that pin's request on the next edge
  for (genvar g = 0; g < 4; g++) begin : g_pin
    property p_pin_edge;
      @(posedge clk) disable iff (!rst_b)
        ((ext_pin[g] && !$past(ext_pin[g]) && rise_sel[g])
          || (!ext_pin[g] && $past(ext_pin[g]) && fall_sel[g]))
        |=> request[g + `VIC_EXT_FIRST];
    endproperty
    a_pin_edge: assert property (p_pin_edge) else $error("pin edge not latched");
  end
endmodule
`default_nettype wire

// ==== verilog/vic_defs.svh ====
// offsets, reset values and timing counts of the interrupt controller
`ifndef VIC_DEFS_SVH
`define VIC_DEFS_SVH
`define VIC_ADDR_RISE     16'hff48
`define VIC_ADDR_FALL     16'hff49
`define VIC_ADDR_BLOCK_A  16'hffe4
`define VIC_ADDR_BLOCK_B  16'hffe5
`define VIC_ADDR_BLOCK_C  16'hffe6
`define VIC_ADDR_LEVEL_A  16'hffe8
`define VIC_ADDR_LEVEL_B  16'hffe9
`define VIC_ADDR_LEVEL_C  16'hffea
`define VIC_ADDR_STATUS   16'hff1e
`define VIC_ADDR_REQ_A    16'hffe0
`define VIC_ADDR_REQ_B    16'hffe1
`define VIC_ADDR_REQ_C    16'hffe2
`define VIC_RST_BLOCK     8'hff
`define VIC_RST_LEVEL     8'hff
`define VIC_RST_EDGE      8'h00
`define VIC_RST_STATUS    8'h02
`define VIC_BIT_ENABLE    7
`define VIC_BIT_PRIO      1
`define VIC_NMI_VECTOR    16'h0004
`define VIC_VEC_BASE      16'h0004
`define VIC_NSRC          24
`define VIC_EXT_FIRST     1
`define VIC_WDT_SRC       0
`define VIC_LAT_MIN_HI    7
`define VIC_LAT_MIN_LO    8
`define VIC_LAT_MAX_HI    32
`define VIC_LAT_MAX_LO    33
`endif

// ==== verilog/vic_pkg.sv ====
// types shared by the interrupt controller
package vic_pkg;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_PUSH_S = 3'b001,
    ST_PUSH_P = 3'b010,
    ST_VECTOR = 3'b011
  } acc_state_t;
endpackage
